// [rlw_defs.vh]
// Constants for the read latency and I/O width configuration block
`ifndef RLW_DEFS_VH
`define RLW_DEFS_VH

// Register byte offsets on the AXI4-Lite bus
`define RLW_REG_LWC     4'h0
`define RLW_REG_IFC     4'h4
`define RLW_REG_STAT    4'h8

// Field positions
`define RLW_LAT_HI      7
`define RLW_LAT_LO      4
`define RLW_QUAD_BIT    1
`define RLW_QPI_BIT     6
`define RLW_IO3_ALT_RESET_ENABLE_BIT    5
`define RLW_DPI_BIT     4

// Writable bits and reset values
`define RLW_LWC_MASK    8'hF2
`define RLW_IFC_MASK    8'h70
`define RLW_LWC_RST     8'h00
`define RLW_IFC_RST     8'h00

// AXI responses
`define RLW_RESP_OKAY   2'h0
`define RLW_RESP_DECERR 2'h3

// Read opcodes (arbitrary encodings)
`define RLW_OP_READ     8'h03
`define RLW_OP_QUICK    8'h0B
`define RLW_OP_DOR      8'h3B
`define RLW_OP_TWO_LANE_IO_READ_CMD     8'hBB
`define RLW_OP_QOR      8'h6B
`define RLW_OP_FOUR_LANE_IO_READ_CMD     8'hEB
`define RLW_OP_DOUBLE_RATE_QUICK_READ_CMD    8'h0D
`define RLW_OP_DOUBLE_RATE_FOUR_LANE_IO_READ_CMD  8'hED
`define RLW_OP_ERROR_CODE_READ_CMD    8'h18
`define RLW_OP_SPECIAL_SECTOR_READ_CMD     8'h4B

// Mode byte cycles per address width
`define RLW_MODE_1L     5'd8
`define RLW_MODE_2L     5'd4
`define RLW_MODE_4L     5'd2
`define RLW_MODE_DDR    5'd1

// Phase lengths in bits, sync reset value, filler byte
`define RLW_CMD_BITS    5'd8
`define RLW_ADDR_BITS   5'd24
`define RLW_SYNC_RST    7'h7F
`define RLW_IDLE_BYTE   8'hFF

`endif

// [rlw_fifo.v]
// Small synchronous FIFO with flush, valid/ready on both sides
`timescale 1ns/10ps
module rlw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
)(
    input  wire             clock,
    input  wire             srst,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    // Full level sized to the counter so the compare is exact
    localparam [AW:0] FULL_CNT = DEPTH;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    // Full and empty straight from the occupancy count
    assign in_ready  = (count != FULL_CNT);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    // Storage has no reset; only pointers and count carry state
    always @(posedge clock) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointer wrap assumes DEPTH is a power of two
    always @(posedge clock) begin
        if (srst | flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule // rlw_fifo

// [rlw_core.v]
// Serial read engine with latency and I/O width configuration
`timescale 1ns/10ps
`include "rlw_defs.vh"
module rlw_core #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
)(
    input  wire        clock,
    input  wire        srst,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        sck,
    input  wire        cs_n,
    input  wire        wp_n,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out,
    output reg  [3:0]  io_oe,
    output reg  [23:0] fetch_addr,
    output reg         fetch_start,
    input  wire        fill_valid,
    output wire        fill_ready,
    input  wire [7:0]  fill_data,
    output reg         write_protect_n,
    output reg         io3_reset_req
);
    localparam ST_IDLE = 6'b000001;
    localparam ST_CMD  = 6'b000010;
    localparam ST_ADDR = 6'b000100;
    localparam ST_WAIT = 6'b001000;
    localparam ST_DATA = 6'b010000;
    localparam ST_SKIP = 6'b100000;

    reg [7:0]  latency_width_config;
    reg [7:0]  interface_config;
    reg [6:0]  s1;
    reg [6:0]  s2;
    reg [1:0]  s3;
    reg [5:0]  state;
    reg [23:0] sh;
    reg [4:0]  cnt;
    reg [2:0]  cur_w;
    reg [2:0]  data_w;
    reg [4:0]  wait_left;
    reg        ddr;
    reg [3:0]  lat_q;
    reg        quad_q;
    reg        two_wire_q;
    reg        four_wire_q;
    reg [7:0]  dout;
    reg [3:0]  dcnt;
    reg        aw_hold;
    reg        w_hold;
    reg [3:0]  aw_addr;
    reg [7:0]  w_byte;
    reg        w_lane0;

    // Decode: {ok, has_mode, ddr, lat_en, addr_w[2:0], data_w[2:0]}
    function [9:0] rlw_decode;
        input [7:0] op;
        begin
            case (op)
                `RLW_OP_READ, `RLW_OP_ERROR_CODE_READ_CMD,
                `RLW_OP_SPECIAL_SECTOR_READ_CMD:    rlw_decode = {4'b1001, 3'd1, 3'd1};
                `RLW_OP_QUICK:   rlw_decode = {4'b1101, 3'd1, 3'd1};
                `RLW_OP_DOR:     rlw_decode = {4'b1101, 3'd1, 3'd2};
                `RLW_OP_TWO_LANE_IO_READ_CMD:    rlw_decode = {4'b1101, 3'd2, 3'd2};
                `RLW_OP_QOR:     rlw_decode = {4'b1101, 3'd1, 3'd4};
                `RLW_OP_FOUR_LANE_IO_READ_CMD:    rlw_decode = {4'b1101, 3'd4, 3'd4};
                `RLW_OP_DOUBLE_RATE_QUICK_READ_CMD,
                `RLW_OP_DOUBLE_RATE_FOUR_LANE_IO_READ_CMD: rlw_decode = {4'b1111, 3'd4, 3'd4};
                default:         rlw_decode = 10'h000;
            endcase
        end
    endfunction

    // Lane mapping: {oe[3:0], out[3:0]}; single line drives line 1
    function [7:0] rlw_lanes;
        input [7:0] b;
        input [2:0] w;
        begin
            case (w)
                3'd4:    rlw_lanes = {4'hF, b[7:4]};
                3'd2:    rlw_lanes = {4'h3, 2'b00, b[7:6]};
                default: rlw_lanes = {4'h2, 2'b00, b[7], 1'b0};
            endcase
        end
    endfunction

    // Pin synchronisers: {sck, cs_n, wp_n, io[3:0]}; s3 only reads s2
    always @(posedge clock) begin
        if (srst) begin
            s1 <= `RLW_SYNC_RST;
            s2 <= `RLW_SYNC_RST;
            s3 <= 2'b11;
        end else begin
            s1 <= {sck, cs_n, wp_n, io_in};
            s2 <= s1;
            s3 <= s2[6:5];
        end
    end

    wire sck_rise = s2[6] & ~s3[1];
    wire sck_fall = ~s2[6] & s3[1];
    wire cs_hi    = s2[5];

    wire       quad_live = latency_width_config[`RLW_QUAD_BIT];
    wire       qpi_live  = interface_config[`RLW_QPI_BIT];
    wire       io3_alt_reset_enable_live = interface_config[`RLW_IO3_ALT_RESET_ENABLE_BIT];
    wire [2:0] proto_w   = four_wire_q ? 3'd4 : (two_wire_q ? 3'd2 : 3'd1);

    // Shift-in of the lines that the current phase uses
    wire [23:0] next_sh = (cur_w == 3'd4) ? {sh[19:0], s2[3:0]} :
                          (cur_w == 3'd2) ? {sh[21:0], s2[1:0]} : {sh[22:0], s2[0]};
    wire [4:0]  cnt_next = cnt + {2'b00, cur_w};

    wire [9:0] dec     = rlw_decode(next_sh[7:0]);
    wire [2:0] dec_aw  = (two_wire_q | four_wire_q) ? proto_w : dec[5:3];
    wire [2:0] dec_dw  = (two_wire_q | four_wire_q) ? proto_w : dec[2:0];
    // Four-wire protocol never needs the quad bit
    wire       no_quad = ((dec_aw == 3'd4) | (dec_dw == 3'd4)) & ~quad_q & ~four_wire_q;
    reg  [4:0] mode_cyc;
    wire [4:0] lat_cyc = dec[6] ? {1'b0, lat_q} : 5'd0;

    // Mode byte cycles per address width and rate
    always @* begin
        if (!dec[8])
            mode_cyc = 5'd0;
        else if (dec[7])
            mode_cyc = `RLW_MODE_DDR;
        else if (dec_aw == 3'd4)
            mode_cyc = `RLW_MODE_4L;
        else if (dec_aw == 3'd2)
            mode_cyc = `RLW_MODE_2L;
        else
            mode_cyc = `RLW_MODE_1L;
    end

    // Output byte source: prefetched data, filler when starved
    wire       fifo_valid;
    wire [7:0] fifo_data;
    wire       data_edge = sck_fall | (ddr & sck_rise);
    wire       fifo_pop  = (state == ST_DATA) & ~cs_hi & data_edge & (dcnt == 4'd0);
    wire [7:0] src       = (dcnt == 4'd0) ? (fifo_valid ? fifo_data : `RLW_IDLE_BYTE) : dout;
    wire [7:0] lanes     = rlw_lanes(src, data_w);
    wire [7:0] src_sh    = (data_w == 3'd4) ? {src[3:0], 4'h0} :
                           (data_w == 3'd2) ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
    wire [3:0] dcnt_base = (dcnt == 4'd0) ? 4'd8 : dcnt;

    // Serial phase sequencer
    always @(posedge clock) begin
        fetch_start <= 1'b0;
        if (srst) begin
            state       <= ST_IDLE;
            sh          <= 24'h000000;
            cnt         <= 5'd0;
            cur_w       <= 3'd1;
            data_w      <= 3'd1;
            wait_left   <= 5'd0;
            ddr         <= 1'b0;
            lat_q       <= 4'h0;
            quad_q      <= 1'b0;
            two_wire_q  <= 1'b0;
            four_wire_q <= 1'b0;
            dout        <= 8'h00;
            dcnt        <= 4'd0;
            io_out      <= 4'h0;
            io_oe       <= 4'h0;
            fetch_addr  <= 24'h000000;
        end else if (cs_hi) begin
            state <= ST_IDLE;
            io_oe <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Snapshot config at select; later writes wait for the next command
                    lat_q       <= latency_width_config[`RLW_LAT_HI:`RLW_LAT_LO];
                    quad_q      <= quad_live;
                    two_wire_q  <= interface_config[`RLW_DPI_BIT];
                    four_wire_q <= qpi_live;
                    cur_w       <= qpi_live ? 3'd4 : (interface_config[`RLW_DPI_BIT] ? 3'd2 : 3'd1);
                    cnt         <= 5'd0;
                    ddr         <= 1'b0;
                    dcnt        <= 4'd0;
                    state       <= ST_CMD;
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        sh  <= next_sh;
                        cnt <= cnt_next;
                        if (cnt_next == `RLW_CMD_BITS) begin
                            cnt <= 5'd0;
                            if (!dec[9] | no_quad) begin
                                state <= ST_SKIP;
                            end else begin
                                cur_w     <= dec_aw;
                                data_w    <= dec_dw;
                                ddr       <= dec[7];
                                // Mode cycles are part of the latency, not added to it
                                wait_left <= (lat_cyc > mode_cyc) ? lat_cyc : mode_cyc;
                                state     <= ST_ADDR;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise | (ddr & sck_fall)) begin
                        sh  <= next_sh;
                        cnt <= cnt_next;
                        if (cnt_next == `RLW_ADDR_BITS) begin
                            fetch_addr  <= next_sh;
                            fetch_start <= 1'b1;
                            // Dummies start only after the last address bit
                            state <= (wait_left == 5'd0) ? ST_DATA : ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // Only rising edges count, so DDR dummies are full periods too
                    if (sck_rise) begin
                        wait_left <= wait_left - 5'd1;
                        if (wait_left == 5'd1)
                            state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (data_edge) begin
                        io_out <= lanes[3:0];
                        io_oe  <= lanes[7:4];
                        dout   <= src_sh;
                        dcnt   <= dcnt_base - {1'b0, data_w};
                    end
                end
                ST_SKIP: begin
                    io_oe <= 4'h0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Write-protect pin and line 3 pin functions
    always @(posedge clock) begin
        if (srst) begin
            write_protect_n <= 1'b1;
            io3_reset_req   <= 1'b0;
        end else begin
            // Write-protect input is ignored while quad width is on
            write_protect_n <= (quad_live | qpi_live) ? 1'b1 : s2[4];
            // Reset function whenever line 3 is not carrying data
            io3_reset_req <= io3_alt_reset_enable_live & ~s2[3] & (cs_hi | ~(quad_live | qpi_live));
        end
    end

    // Prefetch buffer; flushed between commands so stale bytes never leak
    rlw_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .srst      (srst),
        .flush     (cs_hi),
        .in_valid  (fill_valid),
        .in_ready  (fill_ready),
        .in_data   (fill_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge clock) begin
        if (srst) begin
            aw_hold              <= 1'b0;
            w_hold               <= 1'b0;
            aw_addr              <= 4'h0;
            w_byte               <= 8'h00;
            w_lane0              <= 1'b0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= `RLW_RESP_OKAY;
            latency_width_config <= `RLW_LWC_RST;
            interface_config     <= `RLW_IFC_RST;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (aw_hold & w_hold) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RLW_RESP_OKAY;
                // Reserved bits stay zero; status is read-only
                if (aw_addr == `RLW_REG_LWC) begin
                    if (w_lane0)
                        latency_width_config <= w_byte & `RLW_LWC_MASK;
                end else if (aw_addr == `RLW_REG_IFC) begin
                    if (w_lane0)
                        interface_config <= w_byte & `RLW_IFC_MASK;
                end else if (aw_addr != `RLW_REG_STAT) begin
                    s_axi_bresp <= `RLW_RESP_DECERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path, one cycle after address
    always @(posedge clock) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RLW_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RLW_RESP_OKAY;
            case (s_axi_araddr)
                `RLW_REG_LWC:  s_axi_rdata <= {24'h000000, latency_width_config};
                `RLW_REG_IFC:  s_axi_rdata <= {24'h000000, interface_config};
                `RLW_REG_STAT: s_axi_rdata <= {24'h000000, state, write_protect_n, io3_reset_req};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RLW_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // rlw_core

// [rlw_core_props.sv]
// Concurrent checks on the bus, link and fetch ports of the core
`timescale 1ns/10ps
module rlw_core_props (
    input logic        clock,
    input logic        srst,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic [3:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        cs_n,
    input logic [3:0]  io_oe,
    input logic        fetch_start,
    input logic        write_protect_n,
    input logic        io3_reset_req
);
    logic addr_done;

    default clocking dclk @(posedge clock); endclocking
    default disable iff (srst);

    // Address of this frame taken; raw select so a dropped frame clears it at once
    always @(posedge clock) begin
        if (srst || cs_n)
            addr_done <= 1'b0;
        else if (fetch_start)
            addr_done <= 1'b1;
    end

    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer not two cycles after take");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    AST_DECERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
        |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    AST_NO_EARLY: assert property ($rose(io_oe != 4'h0) |-> addr_done)
        else $error("data driven before address done");
    AST_LANES: assert property (io_oe != 4'h0 |-> io_oe inside {4'h2, 4'h3, 4'hF})
        else $error("bad lane set driven");
    AST_IO3_DATA: assert property (io_oe[3] |-> !io3_reset_req)
        else $error("line 3 is data and reset at once");
    AST_WP_QUAD: assert property (io_oe == 4'hF |-> write_protect_n)
        else $error("write protect low in four line mode");
    AST_RELEASE: assert property (cs_n [*8] |-> io_oe == 4'h0)
        else $error("lines driven while deselected");
    AST_PULSE: assert property (fetch_start |=> !fetch_start)
        else $error("fetch start longer than one cycle");
endmodule // rlw_core_props

bind rlw_core rlw_core_props u_props (.*);

// [rlw_host_model.sv]
// Host serial controller model on the link side of the core
`timescale 1ns/10ps
module rlw_host_model (
    input  logic       clock,
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] io,
    input  logic [3:0] io_out,
    input  logic [3:0] io_oe
);
    int          dummies;
    logic [3:0]  first_oe, s_oe, s_out;
    logic [71:0] rx;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io = 4'hA;
    end

    // One full 40-clock sck period, lines sampled just before the rise
    task automatic tick();
        repeat (19) @(posedge clock);
        @(negedge clock);
        s_oe = io_oe;
        s_out = io_out;
        @(posedge clock) sck <= 1'b1;
        repeat (20) @(posedge clock);
        sck <= 1'b0;
    endtask

    // Unused lines toggle so a stale level is never mistaken for a bit
    task automatic shift(input logic [31:0] v, input int n, input int w);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        for (int i = n; i > 0; i -= w) begin
            io <= (~io & ~m) | (4'(v >> (i - w)) & m);
            tick();
        end
    endtask

    // Command, address, then idle rises counted until the core drives
    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int cw, input int aw,
                        input int dw, input int nb);
        int got;
        got = 0;
        dummies = 0;
        first_oe = 4'h0;
        rx = '0;
        cs_n <= 1'b0;
        shift({24'h0, op}, 8, cw);
        shift({8'h0, a}, 24, aw);
        for (int k = 0; k < 24 + nb * 8 / dw && got < nb * 8; k++) begin
            io <= ~io;
            tick();
            if (s_oe != 4'h0) begin
                if (got == 0)
                    first_oe = s_oe;
                rx = (rx << dw) | 72'(dw == 1 ? s_out[1] : dw == 2 ? s_out[1:0] : s_out);
                got += dw;
            end
            else if (got == 0)
                dummies++;
        end
        repeat (20) @(posedge clock);
        cs_n <= 1'b1;
        io <= ~io;
        repeat (40) @(posedge clock);
    endtask
endmodule // rlw_host_model

// [read_latency_io_width_config_tb_top.sv]
// Self-checking bench for the read latency and width configuration core
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module read_latency_io_width_config_tb_top;
    logic        clock = 1'b0, srst = 1'b1, wp_n = 1'b1, fill_valid = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0]  fill_data = 8'h0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [23:0] fetch_addr;
    wire         fetch_start, fill_ready, write_protect_n, io3_reset_req, sck, cs_n;
    wire  [3:0]  io_out, io_oe, host_io;
    wire  [3:0]  io_in = (io_oe & io_out) | (~io_oe & host_io);
    int          failures = 0, compares = 0;
    logic [7:0]  q[$];
    // Opcode, command, address and data lanes, mode cycles per read kind
    logic [7:0]  ops[7] = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hEB};
    int          cw[7] = '{1, 1, 1, 1, 1, 1, 4};
    int          aw[7] = '{1, 1, 1, 2, 1, 4, 4};
    int          dw[7] = '{1, 1, 2, 2, 4, 4, 4};
    int          md[7] = '{0, 8, 8, 4, 8, 2, 2};

    rlw_core #(.FIFO_DEPTH(8), .FIFO_AW(3)) DUT (.*);
    rlw_host_model u_host (.clock, .sck, .cs_n, .io(host_io), .io_out, .io_oe);

    initial forever #2 clock = ~clock;

    function automatic int exp_wait(int lat, int mode);
        return lat > mode ? lat : mode;
    endfunction
    function automatic logic [31:0] lwc(int lat, logic quad);
        return {24'h0, 4'(lat), 2'b00, quad, 1'b0};
    endfunction

    task automatic stop_test();
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Both write channels offered together, each dropped at its own take
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n <= 200; n++) begin
            if (n == 200) begin
                failures++;
                stop_test();
            end
            @(negedge clock);
            {ta, tw, tb, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        s_axi_bready <= 1'b0;
        `CHK(r, er)
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n <= 200; n++) begin
            if (n == 200) begin
                failures++;
                stop_test();
            end
            @(negedge clock);
            {ta, tv, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tv) break;
        end
        s_axi_rready <= 1'b0;
        `CHK(d, e)
        `CHK(r, er)
    endtask

    // Fill stream loaded after select falls; the FIFO is flushed while idle
    task automatic load(input int n);
        logic [7:0] b;
        repeat (100) @(posedge clock);
        for (int k = 0; k < n; k++) begin
            b = 8'($urandom);
            fill_valid <= 1'b1;
            fill_data <= b;
            for (int t = 0; t <= 50; t++) begin
                if (t == 50) begin
                    failures++;
                    stop_test();
                end
                @(negedge clock);
                if (fill_ready) break;
            end
            @(posedge clock);
            q.push_back(b);
        end
        fill_valid <= 1'b0;
        @(negedge clock);
        if (n == 8) `CHK(fill_ready, 1'b0)
    endtask

    // One read frame; nl not negative rewrites the latency mid-frame
    task automatic frame(input int i, input int lat, input int nb, input int push, input int nl, input logic ok);
        logic [23:0] a;
        a = 24'($urandom);
        q.delete();
        fork
            u_host.xfer(ops[i], a, cw[i], aw[i], dw[i], nb);
            load(push);
            if (nl >= 0) begin
                repeat (300) @(posedge clock);
                wr(4'h0, lwc(nl, 1'b1), 4'hF, 2'h0);
            end
        join
        `CHK(u_host.first_oe, ok ? (dw[i] == 1 ? 4'h2 : dw[i] == 2 ? 4'h3 : 4'hF) : 4'h0)
        if (ok) begin
            `CHK(u_host.dummies, exp_wait(lat, md[i]))
            `CHK(fetch_addr, a)
            for (int b = 0; b < nb; b++)
                `CHK(u_host.rx[8 * (nb - 1 - b) +: 8], b < q.size() ? q[b] : 8'hFF)
        end
    endtask

    initial begin
        int lat, n;
        void'($urandom(27584));
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        // Reset values, writable masks, read-only and unmapped places
        rchk(4'h0, 32'h0, 2'h0);
        rchk(4'h4, 32'h0, 2'h0);
        rchk(4'h8, 32'h6, 2'h0);
        wr(4'hC, 32'hFF, 4'hF, 2'h3);
        rchk(4'hC, 32'h0, 2'h3);
        wr(4'h8, 32'h0, 4'hF, 2'h0);
        wr(4'h4, 32'hFF, 4'hF, 2'h0);
        rchk(4'h4, 32'h70, 2'h0);
        wr(4'h4, 32'h0, 4'hF, 2'h0);
        wr(4'h0, 32'hFF, 4'hF, 2'h0);
        wr(4'h0, 32'h0, 4'h0, 2'h0);
        rchk(4'h0, 32'hF2, 2'h0);
        // Read kinds 0 to 5 twice each, latency extremes first; slow sck keeps all codes legal
        for (int r = 0; r < 12; r++) begin
            lat = r < 2 ? r * 15 : $urandom_range(15);
            n = $urandom_range(4, 1);
            wr(4'h0, lwc(lat, 1'b1), 4'hF, 2'h0);
            frame(r % 6, lat, n, n, -1, 1'b1);
        end
        wr(4'h0, lwc(5, 1'b0), 4'hF, 2'h0);
        frame(4, 5, 2, 0, -1, 1'b0);
        wr(4'h4, 32'h40, 4'hF, 2'h0);
        frame(6, 5, 2, 2, -1, 1'b1);
        wr(4'h4, 32'h0, 4'hF, 2'h0);
        wr(4'h0, lwc(4, 1'b1), 4'hF, 2'h0);
        frame(0, 4, 9, 8, 9, 1'b1);
        frame(0, 9, 1, 1, -1, 1'b1);
        // Protect pin and line 3 alternate function
        wp_n <= 1'b0;
        wr(4'h0, 32'h0, 4'hF, 2'h0);
        repeat (10) @(negedge clock);
        `CHK(write_protect_n, 1'b0)
        wr(4'h0, 32'h2, 4'hF, 2'h0);
        repeat (10) @(negedge clock);
        `CHK(write_protect_n, 1'b1)
        wr(4'h4, 32'h20, 4'hF, 2'h0);
        u_host.io[3] <= 1'b0;
        repeat (10) @(negedge clock);
        `CHK(io3_reset_req, 1'b1)
        @(posedge clock);
        u_host.cs_n <= 1'b0;
        repeat (10) @(negedge clock);
        `CHK(io3_reset_req, 1'b0)
        stop_test();
    end
endmodule // read_latency_io_width_config_tb_top
